/* File: design/tmbc_engine.sv */
// One march-test engine for a single local RAM, with peek and poke.
// Assumes a RAM with single-cycle issue, read data and error valid in the same cycle as an unstalled issue, wait extends.
`timescale 1ns/1ps
`include "tmbc_map.svh"
module tmbc_engine
  import tmbc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    ctl_wr,
  input  wire logic                    ctl_enable,
  input  wire logic                    ctl_start,
  input  wire logic                    ctl_pause,
  input  wire logic [`TMBC_SIZE_W-1:0] ctl_size,
  input  wire logic                    addr_wr,
  input  wire logic                    gen_wr,
  input  wire logic [31:0]             wdata,
  output logic [`TMBC_SIZE_W-1:0]      size_ff,
  output logic                         enable_ff,
  output logic                         pause_ff,
  output logic                         running_ff,
  output logic                         done_ff,
  output logic                         fail_ff,
  output logic                         busy_ff,
  output logic [31:0]                  fail_addr_ff,
  output logic [31:0]                  fail_data_ff,
  output logic [31:0]                  peek_data_ff,
  output logic                         ram_cs_ff,
  output logic                         ram_wr_ff,
  output logic [`TMBC_AW-1:0]          ram_addr_ff,
  output logic [31:0]                  ram_wdata_ff,
  input  wire logic [31:0]             ram_rdata,
  input  wire logic                    ram_wait,
  input  wire logic                    ram_error
);
  tmbc_state_e                state_ff, nxt_state;
  logic [`TMBC_AW-1:0]        base_ff;
  logic [`TMBC_AW-1:0]        ptr_ff, nxt_ptr;
  logic [31:0]                pat_ff;
  logic                       auto_ff;
  logic                       rd_pend_ff;
  logic [31:0]                expect_ff;
  logic [`TMBC_AW-1:0]        top_w;
  logic                       issue_ok, mismatch;
  tmbc_state_e                resume_ff;

  // Region length in words: 2^(size-1) KB is 2^(size+7) words, size 0 tests nothing
  function automatic logic [`TMBC_AW-1:0] region_top(input logic [`TMBC_AW-1:0] base,
                                                     input logic [`TMBC_SIZE_W-1:0] sz);
    logic [`TMBC_AW:0] words;
    words = (sz == 5'h00) ? '0 : ((`TMBC_AW+1)'(1) << (sz + 5'h07));
    return base + words[`TMBC_AW-1:0] - `TMBC_AW'(1);
  endfunction

  assign top_w    = region_top(base_ff, size_ff);
  assign issue_ok = !ram_wait;
  assign mismatch = rd_pend_ff && issue_ok && ((ram_rdata != expect_ff) || ram_error);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable_ff <= 1'b0;
      pause_ff  <= 1'b0;
      size_ff   <= '0;
    end else if (ctl_wr) begin
      enable_ff <= ctl_enable;
      pause_ff  <= ctl_pause;
      size_ff   <= ctl_size;
    end
  end

  // Start address and peek/poke address share storage; low bits and high bits dropped
  always_ff @(posedge clk) begin
    if (!reset_n)
      base_ff <= '0;
    else if (addr_wr)
      base_ff <= wdata[`TMBC_AW+1:2];
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      pat_ff <= `TMBC_PATTERN_RESET;
    else if (gen_wr)
      pat_ff <= wdata;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_ptr   = ptr_ff;
    if (mismatch)
      nxt_state = TMBC_IDLE;
    else if (issue_ok) begin
      case (state_ff)
        TMBC_P1_WR: begin
          if (ptr_ff == top_w) begin
            nxt_ptr   = base_ff;
            nxt_state = auto_ff ? TMBC_PAUSED : TMBC_P2_RD;
          end else
            nxt_ptr = ptr_ff + `TMBC_AW'(1);
        end
        TMBC_P2_RD:  nxt_state = TMBC_P2_WRI;
        TMBC_P2_WRI: nxt_state = TMBC_P2_RDI;
        TMBC_P2_RDI: begin
          if (ptr_ff == top_w)
            nxt_state = TMBC_P3_WR;
          else begin
            nxt_ptr   = ptr_ff + `TMBC_AW'(1);
            nxt_state = TMBC_P2_RD;
          end
        end
        TMBC_P3_WR:  nxt_state = TMBC_P3_RD;
        TMBC_P3_RD: begin
          if (ptr_ff == base_ff)
            nxt_state = (auto_ff && resume_ff == TMBC_P1_WR) ? TMBC_PAUSED : TMBC_IDLE;
          else begin
            nxt_ptr   = ptr_ff - `TMBC_AW'(1);
            nxt_state = TMBC_P3_WR;
          end
        end
        TMBC_PEEK, TMBC_POKE: nxt_state = TMBC_PAUSED;
        default: nxt_state = state_ff;
      endcase
    end
  end

  // Sequencer: start, resume, user pause, peek and poke launch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff  <= TMBC_IDLE;
      resume_ff <= TMBC_P1_WR;
      ptr_ff    <= '0;
      auto_ff   <= 1'b0;
    end else if (ctl_wr && ctl_start && ctl_enable && state_ff == TMBC_PAUSED) begin
      state_ff  <= resume_ff;
      auto_ff   <= ctl_pause;
    end else if (ctl_wr && ctl_start && ctl_enable && state_ff == TMBC_IDLE && size_ff != '0) begin
      state_ff  <= TMBC_P1_WR;
      resume_ff <= TMBC_P1_WR;
      ptr_ff    <= base_ff;
      auto_ff   <= ctl_pause;
    end else if (ctl_wr && ctl_pause && !auto_ff && running_ff && !mismatch) begin
      state_ff  <= TMBC_PAUSED;
      resume_ff <= state_ff;
    end else if (state_ff == TMBC_PAUSED && pause_ff && addr_wr) begin
      state_ff  <= TMBC_PEEK;
    end else if (state_ff == TMBC_PAUSED && pause_ff && gen_wr) begin
      state_ff  <= TMBC_POKE;
    end else begin
      if (nxt_state == TMBC_PAUSED && (state_ff == TMBC_P1_WR || state_ff == TMBC_P3_RD))
        resume_ff <= (state_ff == TMBC_P1_WR) ? TMBC_P2_RD : TMBC_IDLE;
      state_ff <= nxt_state;
      ptr_ff   <= nxt_ptr;
    end
  end

  // RAM port: one access per unstalled cycle, never sequential
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ram_cs_ff    <= 1'b0;
      ram_wr_ff    <= 1'b0;
      ram_addr_ff  <= '0;
      ram_wdata_ff <= '0;
      rd_pend_ff   <= 1'b0;
      expect_ff    <= '0;
    end else if (issue_ok || !ram_cs_ff) begin
      ram_cs_ff  <= 1'b0;
      ram_wr_ff  <= 1'b0;
      rd_pend_ff <= 1'b0;
      ram_addr_ff <= (state_ff == TMBC_PEEK || state_ff == TMBC_POKE) ? base_ff : ptr_ff;
      case (state_ff)
        TMBC_P1_WR, TMBC_P3_WR: begin
          ram_cs_ff <= !mismatch; ram_wr_ff <= 1'b1; ram_wdata_ff <= pat_ff;
        end
        TMBC_P2_WRI: begin
          ram_cs_ff <= !mismatch; ram_wr_ff <= 1'b1; ram_wdata_ff <= ~pat_ff;
        end
        TMBC_P2_RD, TMBC_P3_RD: begin
          ram_cs_ff <= !mismatch; rd_pend_ff <= !mismatch; expect_ff <= pat_ff;
        end
        TMBC_P2_RDI: begin
          ram_cs_ff <= !mismatch; rd_pend_ff <= !mismatch; expect_ff <= ~pat_ff;
        end
        TMBC_POKE: begin
          ram_cs_ff <= 1'b1; ram_wr_ff <= 1'b1; ram_wdata_ff <= pat_ff;
        end
        TMBC_PEEK: ram_cs_ff <= 1'b1;
        default: ram_cs_ff <= 1'b0;
      endcase
    end
  end

  // Peek capture and core stall while a peek or poke is outstanding
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      peek_data_ff <= '0;
      busy_ff      <= 1'b0;
    end else begin
      busy_ff <= (state_ff == TMBC_PAUSED && pause_ff && (addr_wr || gen_wr)) ||
                 state_ff == TMBC_PEEK || state_ff == TMBC_POKE ||
                 (ram_cs_ff && !issue_ok && (state_ff == TMBC_PAUSED));
      if (ram_cs_ff && !ram_wr_ff && issue_ok && state_ff == TMBC_PAUSED)
        peek_data_ff <= ram_rdata;
    end
  end

  // Done and fail flags keep their value between tests; cleared only by a fresh start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      running_ff   <= 1'b0;
      done_ff      <= 1'b0;
      fail_ff      <= 1'b0;
      fail_addr_ff <= '0;
      fail_data_ff <= '0;
    end else begin
      running_ff <= (nxt_state != TMBC_IDLE && nxt_state != TMBC_PAUSED &&
                     nxt_state != TMBC_PEEK && nxt_state != TMBC_POKE) &&
                    !(ctl_wr && ctl_pause && !auto_ff);
      // A late failing compare wins over a start in the same cycle, so no failure is lost
      if (mismatch) begin
        done_ff      <= 1'b1;
        fail_ff      <= 1'b1;
        fail_addr_ff <= {ram_error, {(31-`TMBC_AW-2){1'b0}}, ram_addr_ff, 2'b00};
        fail_data_ff <= ram_rdata;
      end else if (ctl_wr && ctl_start && ctl_enable && state_ff == TMBC_IDLE) begin
        done_ff      <= 1'b0;
        fail_ff      <= 1'b0;
        fail_addr_ff <= '0;
        fail_data_ff <= '0;
      end else if (state_ff == TMBC_PAUSED && pause_ff && (addr_wr || gen_wr)) begin
        fail_addr_ff <= '0;
        fail_data_ff <= '0;
      end else if (state_ff == TMBC_P3_RD && nxt_state == TMBC_IDLE)
        done_ff <= 1'b1;
    end
  end
endmodule // tmbc_engine

/* File: design/tmbc_map.svh */
// Register decode, control field positions and sizes for the local RAM self-test controller.
// Included by the design modules and the sim files; holds definitions only.
`ifndef TMBC_MAP_SVH
`define TMBC_MAP_SVH
// Register select codes on the coprocessor access port
`define TMBC_SEL_CTRL        2'h0
`define TMBC_SEL_ADDR        2'h1
`define TMBC_SEL_GEN         2'h2
// Per-engine control field, instruction engine low byte, data engine next byte
`define TMBC_CTL_DATA_SHIFT  8
`define TMBC_CTL_ENABLE      0
`define TMBC_CTL_START       1
`define TMBC_CTL_PAUSE       2
`define TMBC_CTL_SIZE_LSB    3
`define TMBC_CTL_SIZE_W      5
`define TMBC_SIZE_W          `TMBC_CTL_SIZE_W
// Status field, instruction engine bits 19:16, data engine 23:20
`define TMBC_STS_LSB         16
`define TMBC_STS_DATA_SHIFT  4
// Word address width of each local RAM, 24-bit byte address
`define TMBC_AW              22
`define TMBC_ERR_BIT         31
`define TMBC_PATTERN_RESET   32'h0000_0000
`endif

/* File: design/tmbc_pkg.sv */
// Types shared by the self-test engine and the two-engine top.
// Assumes tmbc_map.svh sits in the include path.
package tmbc_pkg;
  typedef enum logic [3:0] {
    TMBC_IDLE, TMBC_P1_WR, TMBC_P2_RD, TMBC_P2_WRI, TMBC_P2_RDI,
    TMBC_P3_WR, TMBC_P3_RD, TMBC_PAUSED, TMBC_PEEK, TMBC_POKE
  } tmbc_state_e;
endpackage

/* File: design/tmbc_top.sv */
// Two independent local RAM self-test engines behind the coprocessor register port.
// Assumes register accesses arrive as one-cycle strobes synchronous to clk; rdata valid the cycle after a read.
// Summary of operation
// - Two independent engines test instruction and data RAM, alone or together.
// - While self-test is enabled, that RAM's functional enable is cleared.
// - First pass writes the pattern upward through the region.
// - Second pass checks pattern, writes inverse, checks inverse; mismatch fails.
// - Third pass walks downward writing then checking the pattern.
// - Error input fails any test read; sequential flag always low.
// - Control read shows running, paused, failed, completed, size and enable.
// - Address registers hold word addresses; low two bits and bits 30:24 read zero.
// - Pause bit selects start/peek-poke address and pattern/poke or fail/peek data.
// - Aliased registers share storage, so writes overwrite each other.
// - Fail address and data cleared on new test start or peek/poke.
// - Fail address top bit marks an error-input failure.
// - Running while testing; failure stores details and sets done and fail.
// - Pause clears running; done and fail reset only on a new start.
// - Address write launches a peek read; core stalls until data returns.
// - Poke write launches a RAM write; later accesses stall until done.
// - Pause set at start gives auto pause at end of first pass.
// - In user mode setting pause halts; start resumes.
// - Everything clocked on the rising edge of the one core clock.
`timescale 1ns/1ps
`include "tmbc_map.svh"
module tmbc_top
  import tmbc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                coproc_register_write,
  input  wire logic                coproc_register_read,
  input  wire logic                reg_is_data,
  input  wire logic [1:0]          reg_sel,
  input  wire logic [31:0]         reg_wdata,
  output logic [31:0]              reg_rdata_ff,
  output logic                     core_stall_ff,
  output logic                     instr_func_enable_clear_ff,
  output logic                     data_func_enable_clear_ff,
  output logic                     instr_ram_cs_ff,
  output logic                     instr_ram_wr_ff,
  output logic [`TMBC_AW-1:0]      instr_ram_addr_ff,
  output logic [31:0]              instr_ram_wdata_ff,
  output logic                     instr_sequential_access_flag_ff,
  input  wire logic [31:0]         instr_ram_rdata,
  input  wire logic                instr_ram_wait,
  input  wire logic                instr_ram_error_in,
  output logic                     data_ram_cs_ff,
  output logic                     data_ram_wr_ff,
  output logic [`TMBC_AW-1:0]      data_ram_addr_ff,
  output logic [31:0]              data_ram_wdata_ff,
  output logic                     data_sequential_access_flag_ff,
  input  wire logic [31:0]         data_ram_rdata,
  input  wire logic                data_ram_wait,
  input  wire logic                data_ram_error_in
);
  logic                     ctl_wr;
  logic [1:0]               a_wr, g_wr;
  logic [`TMBC_SIZE_W-1:0]  size_w  [2];
  logic [1:0]               en_w, pz_w, run_w, dn_w, fl_w, by_w;
  logic [31:0]              fa_w [2];
  logic [31:0]              fd_w [2];
  logic [31:0]              pk_w [2];
  logic [31:0]              ctl_rd;
  logic [7:0]               icf_w, dcf_w;

  function automatic logic [7:0] ctl_field(input logic [31:0] d, input logic data_eng);
    return data_eng ? d[`TMBC_CTL_DATA_SHIFT +: 8] : d[7:0];
  endfunction

  assign ctl_wr  = coproc_register_write && reg_sel == `TMBC_SEL_CTRL;
  assign a_wr[0] = coproc_register_write && reg_sel == `TMBC_SEL_ADDR && !reg_is_data;
  assign a_wr[1] = coproc_register_write && reg_sel == `TMBC_SEL_ADDR &&  reg_is_data;
  assign g_wr[0] = coproc_register_write && reg_sel == `TMBC_SEL_GEN  && !reg_is_data;
  assign g_wr[1] = coproc_register_write && reg_sel == `TMBC_SEL_GEN  &&  reg_is_data;
  assign icf_w   = ctl_field(reg_wdata, 1'b0);
  assign dcf_w   = ctl_field(reg_wdata, 1'b1);

  // Control write carries both engines' fields so both can start together
  tmbc_engine u_instr_mem_selftest (
    .clk(clk), .reset_n(reset_n), .ctl_wr(ctl_wr),
    .ctl_enable(icf_w[`TMBC_CTL_ENABLE]),
    .ctl_start(icf_w[`TMBC_CTL_START]),
    .ctl_pause(icf_w[`TMBC_CTL_PAUSE]),
    .ctl_size(icf_w[`TMBC_CTL_SIZE_LSB +: `TMBC_SIZE_W]),
    .addr_wr(a_wr[0]), .gen_wr(g_wr[0]), .wdata(reg_wdata),
    .size_ff(size_w[0]), .enable_ff(en_w[0]), .pause_ff(pz_w[0]), .running_ff(run_w[0]),
    .done_ff(dn_w[0]), .fail_ff(fl_w[0]), .busy_ff(by_w[0]), .fail_addr_ff(fa_w[0]),
    .fail_data_ff(fd_w[0]), .peek_data_ff(pk_w[0]),
    .ram_cs_ff(instr_ram_cs_ff), .ram_wr_ff(instr_ram_wr_ff), .ram_addr_ff(instr_ram_addr_ff),
    .ram_wdata_ff(instr_ram_wdata_ff), .ram_rdata(instr_ram_rdata),
    .ram_wait(instr_ram_wait), .ram_error(instr_ram_error_in)
  );

  tmbc_engine u_data_mem_selftest (
    .clk(clk), .reset_n(reset_n), .ctl_wr(ctl_wr),
    .ctl_enable(dcf_w[`TMBC_CTL_ENABLE]),
    .ctl_start(dcf_w[`TMBC_CTL_START]),
    .ctl_pause(dcf_w[`TMBC_CTL_PAUSE]),
    .ctl_size(dcf_w[`TMBC_CTL_SIZE_LSB +: `TMBC_SIZE_W]),
    .addr_wr(a_wr[1]), .gen_wr(g_wr[1]), .wdata(reg_wdata),
    .size_ff(size_w[1]), .enable_ff(en_w[1]), .pause_ff(pz_w[1]), .running_ff(run_w[1]),
    .done_ff(dn_w[1]), .fail_ff(fl_w[1]), .busy_ff(by_w[1]), .fail_addr_ff(fa_w[1]),
    .fail_data_ff(fd_w[1]), .peek_data_ff(pk_w[1]),
    .ram_cs_ff(data_ram_cs_ff), .ram_wr_ff(data_ram_wr_ff), .ram_addr_ff(data_ram_addr_ff),
    .ram_wdata_ff(data_ram_wdata_ff), .ram_rdata(data_ram_rdata),
    .ram_wait(data_ram_wait), .ram_error(data_ram_error_in)
  );

  // Paused flag is the pause bit with running low
  always_comb begin
    ctl_rd = '0;
    ctl_rd[`TMBC_CTL_ENABLE] = en_w[0];
    ctl_rd[`TMBC_CTL_PAUSE]  = pz_w[0];
    ctl_rd[`TMBC_CTL_SIZE_LSB +: `TMBC_SIZE_W] = size_w[0];
    ctl_rd[`TMBC_CTL_DATA_SHIFT + `TMBC_CTL_ENABLE] = en_w[1];
    ctl_rd[`TMBC_CTL_DATA_SHIFT + `TMBC_CTL_PAUSE]  = pz_w[1];
    ctl_rd[`TMBC_CTL_DATA_SHIFT + `TMBC_CTL_SIZE_LSB +: `TMBC_SIZE_W] = size_w[1];
    ctl_rd[`TMBC_STS_LSB +: 4] = {dn_w[0], fl_w[0], pz_w[0] & ~run_w[0], run_w[0]};
    ctl_rd[`TMBC_STS_LSB + `TMBC_STS_DATA_SHIFT +: 4] = {dn_w[1], fl_w[1], pz_w[1] & ~run_w[1], run_w[1]};
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      reg_rdata_ff <= '0;
    else if (coproc_register_read) begin
      case (reg_sel)
        `TMBC_SEL_CTRL: reg_rdata_ff <= ctl_rd;
        `TMBC_SEL_ADDR: reg_rdata_ff <= fa_w[reg_is_data];
        `TMBC_SEL_GEN:  reg_rdata_ff <= pz_w[reg_is_data] ? pk_w[reg_is_data] : fd_w[reg_is_data];
        default:        reg_rdata_ff <= '0;
      endcase
    end
  end

  // Stall holds the core while either engine has a peek or poke in flight
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_stall_ff                   <= 1'b0;
      instr_func_enable_clear_ff      <= 1'b0;
      data_func_enable_clear_ff       <= 1'b0;
      instr_sequential_access_flag_ff <= 1'b0;
      data_sequential_access_flag_ff  <= 1'b0;
    end else begin
      core_stall_ff              <= |by_w;
      instr_func_enable_clear_ff <= en_w[0];
      data_func_enable_clear_ff  <= en_w[1];
      instr_sequential_access_flag_ff <= 1'b0;
      data_sequential_access_flag_ff  <= 1'b0;
    end
  end
endmodule // tmbc_top

/* File: sim/tmbc_ram_model.sv */
// Behavioural local RAM for one engine, with optional wait states and an error hook.
// Assumes the engine holds its request while wait is high and compares read data while the read stands.
`timescale 1ns/1ps
`include "tmbc_map.svh"
module tmbc_ram_model (
  input  wire logic                clk,
  input  wire logic                slow,
  input  wire logic                err_en,
  input  wire logic [`TMBC_AW-1:0] err_addr,
  input  wire logic                cs,
  input  wire logic                wr,
  input  wire logic [`TMBC_AW-1:0] addr,
  input  wire logic [31:0]         wdata,
  output logic      [31:0]         rdata,
  output logic                     wait_o,
  output logic                     error
);
  logic [31:0] mem [0:1023];
  logic        ph = 1'b0;
  // Wait on every other cycle when slow, so a request that is not held gets lost
  assign wait_o = slow & ph;
  // Read data follows the held address, so it is settled in the cycle the read stands
  assign rdata  = mem[addr[9:0]];
  assign error  = err_en && cs && !wr && addr == err_addr;
  always @(posedge clk) begin
    ph <= ~ph;
    if (cs && !wait_o && wr) mem[addr[9:0]] <= wdata;
  end
endmodule // tmbc_ram_model

/* File: sim/tmbc_top_checker.sv */
// Port checker for the two-engine self-test top.
// Assumes one clock domain; bound to every tmbc_top.
`timescale 1ns/1ps
`include "tmbc_map.svh"
module tmbc_top_checker (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                coproc_register_write,
  input wire logic                coproc_register_read,
  input wire logic [1:0]          reg_sel,
  input wire logic [31:0]         reg_wdata,
  input wire logic [31:0]         reg_rdata_ff,
  input wire logic                core_stall_ff,
  input wire logic                instr_func_enable_clear_ff,
  input wire logic                instr_ram_cs_ff,
  input wire logic                instr_ram_wr_ff,
  input wire logic [`TMBC_AW-1:0] instr_ram_addr_ff,
  input wire logic                instr_ram_wait,
  input wire logic                data_ram_cs_ff,
  input wire logic                data_ram_wr_ff,
  input wire logic [`TMBC_AW-1:0] data_ram_addr_ff,
  input wire logic                data_ram_wait,
  input wire logic                instr_sequential_access_flag_ff,
  input wire logic                data_sequential_access_flag_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_ctl_wr;
    coproc_register_write && reg_sel == 2'h0 && reg_wdata[0];
  endsequence
  sequence s_istart;
    s_ctl_wr ##0 reg_wdata[1] && reg_wdata[7:3] != 5'h00;
  endsequence
  AST_SEQ_LOW: assert property (!instr_sequential_access_flag_ff && !data_sequential_access_flag_ff)
    else $error("sequential flag high");
  AST_WAIT_HOLD: assert property (instr_ram_cs_ff && instr_ram_wait |=>
    instr_ram_cs_ff && $stable(instr_ram_addr_ff) && $stable(instr_ram_wr_ff)) else $error("request dropped");
  AST_DWAIT_HOLD: assert property (data_ram_cs_ff && data_ram_wait |=>
    data_ram_cs_ff && $stable(data_ram_addr_ff) && $stable(data_ram_wr_ff)) else $error("data request dropped");
  AST_ADDR_WORD: assert property (coproc_register_read && reg_sel == 2'h1 |=>
    reg_rdata_ff[1:0] == 2'h0 && reg_rdata_ff[30:24] == 7'h00) else $error("address bits not zero");
  AST_FENA: assert property (s_ctl_wr |-> ##[1:2] instr_func_enable_clear_ff)
    else $error("functional enable not cleared");
  AST_NO_RAM: assert property (!instr_func_enable_clear_ff |-> !instr_ram_cs_ff) else $error("access untested");
  AST_STALL_END: assert property (core_stall_ff |-> ##[1:16] !core_stall_ff) else $error("stall too long");
  AST_STALL_CAUSE: assert property ($rose(core_stall_ff) |->
    $past(coproc_register_write) || $past(coproc_register_write, 2)) else $error("stall without write");
  AST_START_RUN: assert property (s_istart |-> ##[1:3] instr_ram_cs_ff) else $error("test not started");
endmodule // tmbc_top_checker
bind tmbc_top tmbc_top_checker i_chk (.clk(clk), .reset_n(reset_n), .coproc_register_write(coproc_register_write),
  .coproc_register_read(coproc_register_read), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
  .core_stall_ff(core_stall_ff), .instr_func_enable_clear_ff(instr_func_enable_clear_ff),
  .instr_ram_cs_ff(instr_ram_cs_ff), .instr_ram_wr_ff(instr_ram_wr_ff), .instr_ram_addr_ff(instr_ram_addr_ff),
  .instr_ram_wait(instr_ram_wait), .instr_sequential_access_flag_ff(instr_sequential_access_flag_ff),
  .data_ram_cs_ff(data_ram_cs_ff), .data_ram_wr_ff(data_ram_wr_ff), .data_ram_addr_ff(data_ram_addr_ff),
  .data_ram_wait(data_ram_wait),
  .data_sequential_access_flag_ff(data_sequential_access_flag_ff));

/* File: sim/tcm_memory_bist_controller_tb.sv */
// Bench: both engines, fast instruction RAM, slow data RAM with error hook.
// Assumes the design, the RAM model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "tmbc_map.svh"
module tcm_memory_bist_controller_tb;
  localparam logic [31:0] PAT = 32'hA5C3_0F96;
  logic                clk = 1'b0, reset_n = 1'b0, cw = 1'b0, cr = 1'b0, isd = 1'b0, d_ee = 1'b0, stall;
  logic [1:0]          sel = 2'h0;
  logic [31:0]         wdata = 32'h0, rdata, i_wd, i_rd, d_wd, d_rd;
  logic                i_cs, i_wr, i_wt, i_er, d_cs, d_wr, d_wt, d_er, i_fe, d_fe;
  logic [`TMBC_AW-1:0] i_a, d_a;
  int                  errors = 0, check_count = 0;
  always #12.5 clk = ~clk;
  tmbc_top i_dut (.clk(clk), .reset_n(reset_n), .coproc_register_write(cw), .coproc_register_read(cr),
    .reg_is_data(isd), .reg_sel(sel), .reg_wdata(wdata), .reg_rdata_ff(rdata), .core_stall_ff(stall),
    .instr_func_enable_clear_ff(i_fe), .data_func_enable_clear_ff(d_fe),
    .instr_ram_cs_ff(i_cs), .instr_ram_wr_ff(i_wr),
    .instr_ram_addr_ff(i_a), .instr_ram_wdata_ff(i_wd), .instr_sequential_access_flag_ff(), .instr_ram_rdata(i_rd),
    .instr_ram_wait(i_wt), .instr_ram_error_in(i_er), .data_ram_cs_ff(d_cs), .data_ram_wr_ff(d_wr),
    .data_ram_addr_ff(d_a), .data_ram_wdata_ff(d_wd), .data_sequential_access_flag_ff(), .data_ram_rdata(d_rd),
    .data_ram_wait(d_wt), .data_ram_error_in(d_er));
  tmbc_ram_model i_iram (.clk(clk), .slow(1'b0), .err_en(1'b0), .err_addr(22'h0), .cs(i_cs), .wr(i_wr),
    .addr(i_a), .wdata(i_wd), .rdata(i_rd), .wait_o(i_wt), .error(i_er));
  tmbc_ram_model i_dram (.clk(clk), .slow(1'b1), .err_en(d_ee), .err_addr(22'h45), .cs(d_cs), .wr(d_wr),
    .addr(d_a), .wdata(d_wd), .rdata(d_rd), .wait_o(d_wt), .error(d_er));
  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: read %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Core holds off while a peek or poke is outstanding
  task automatic hold;
    int n;
    n = 0;
    @(negedge clk);
    while (stall !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      chk(32'h1, 32'h0);
      final_report();
    end
  endtask
  task automatic wr(input logic d, input logic [1:0] s, input logic [31:0] v);
    hold();
    {cw, isd, sel, wdata} = {1'b1, d, s, v};
    @(negedge clk);
    cw = 1'b0;
  endtask
  task automatic rd(input logic d, input logic [1:0] s, output logic [31:0] v);
    hold();
    {cr, isd, sel} = {1'b1, d, s};
    @(negedge clk);
    cr = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Control byte: size code 1 (256 words), pause, start, enable
  function automatic logic [7:0] cb(input logic st, input logic pa);
    return {5'h01, pa, st, 1'b1};
  endfunction
  task automatic poll(input int lsb, input logic [3:0] exp);
    logic [31:0] v;
    int          n;
    n = 0;
    do begin
      rd(1'b0, 2'h0, v);
      n++;
    end while (v[lsb+:4] !== exp && n < 3000);
    chk({28'h0, v[lsb+:4]}, {28'h0, exp});
    if (v[lsb+:4] !== exp) final_report();
  endtask
  task automatic scen_both;
    logic [31:0] v;
    wr(1'b0, 2'h0, {16'h0, cb(0, 0), cb(0, 0)});
    wr(1'b0, 2'h1, 32'hFF00_0103);
    wr(1'b1, 2'h1, 32'h0000_0100);
    wr(1'b0, 2'h2, PAT);
    wr(1'b1, 2'h2, PAT);
    wr(1'b0, 2'h0, {16'h0, cb(1, 0), cb(1, 0)});
    poll(16, 4'h1);
    poll(16, 4'h8);
    poll(20, 4'h8);
    rd(1'b0, 2'h0, v);
    chk({20'h0, v[15:11], v[8], v[7:3], v[0]}, {20'h0, 5'h01, 1'b1, 5'h01, 1'b1});
    rd(1'b0, 2'h3, v);
    chk(v, 32'h0);
  endtask
  task automatic scen_error;
    logic [31:0] v;
    d_ee = 1'b1;
    wr(1'b0, 2'h0, {16'h0, cb(0, 0), 8'h00});
    wr(1'b0, 2'h0, {16'h0, cb(1, 0), 8'h00});
    poll(20, 4'hC);
    rd(1'b1, 2'h1, v);
    chk(v, 32'h8000_0114);
    rd(1'b1, 2'h2, v);
    chk(v, PAT);
    chk({31'h0, d_fe}, 32'h1);
    d_ee = 1'b0;
  endtask
  task automatic scen_pause;
    logic [31:0] v;
    wr(1'b0, 2'h0, {16'h0, 8'h00, cb(0, 0)});
    wr(1'b0, 2'h1, 32'h0000_0100);
    wr(1'b0, 2'h2, PAT);
    wr(1'b0, 2'h0, {16'h0, 8'h00, cb(1, 1)});
    poll(16, 4'h2);
    rd(1'b0, 2'h1, v);
    chk(v, 32'h0);
    wr(1'b0, 2'h1, 32'h0000_0140);
    rd(1'b0, 2'h2, v);
    chk(v, PAT);
    wr(1'b0, 2'h2, 32'h1234_5678);
    wr(1'b0, 2'h1, 32'h0000_0140);
    rd(1'b0, 2'h2, v);
    chk(v, 32'h1234_5678);
    wr(1'b0, 2'h0, {16'h0, 8'h00, cb(0, 0)});
    wr(1'b0, 2'h1, 32'h0000_0100);
    wr(1'b0, 2'h2, PAT);
    wr(1'b0, 2'h0, {16'h0, 8'h00, cb(1, 0)});
    poll(16, 4'hC);
    rd(1'b0, 2'h1, v);
    chk(v, 32'h0000_0140);
    rd(1'b0, 2'h2, v);
    chk(v, 32'h1234_5678);
    wr(1'b0, 2'h0, 32'h0);
    rd(1'b0, 2'h0, v);
    chk({31'h0, i_fe}, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    scen_both();
    scen_error();
    scen_pause();
    final_report();
  end
endmodule // tcm_memory_bist_controller_tb
